// File: design/ccpa_top.sv
// counter array top: shared counter, registers, five modules
`timescale 1ns/1ps
module ccpa_top
  import ccpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_MOD-1:0] module_pin_i,
  output logic [NUM_MOD-1:0] module_pin_o,
  output logic [NUM_MOD-1:0] module_pin_oe_o,
  output logic irq_o,
  output logic internal_reset_o
);
  // whole register state of the array
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // shared counter high and low
    logic run; // counter running
    logic watchdog_reset_enable; // watchdog_reset_enable
    logic [NUM_MOD-1:0] flag; // module_event_flag bits
    logic [NUM_MOD-1:0][MODE_W-1:0] mode; // module_mode_register
    logic [NUM_MOD-1:0][CNT_W-1:0] ccap; // capture/compare pairs
    logic irq; // interrupt request
    logic wdt_rst; // internal reset pulse
  } ccpa_state_t;

  ccpa_state_t q, d;

  ccpa_reg_if rif (); // bus to register file path

  // per-module event lines
  logic [NUM_MOD-1:0] cap_ev; // capture strobes
  logic [NUM_MOD-1:0] set_ev; // flag set strobes
  logic [NUM_MOD-1:0] reload_ev; // pwm reload strobes
  logic [NUM_MOD-1:0] wdt_ev; // watchdog matches

  // decode helpers
  logic [3:0] mode_hit; // {hit, index} into mode bank
  logic [3:0] ccap_hit; // {hit, index} into capture bank
  logic [2:0] mode_idx;
  logic [2:0] ccap_idx;

  // bus slave
  ccpa_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rif(rif.port)
  );

  // five modules on the one shared counter
  for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod
    ccpa_channel #(
      .IS_WDT(i == WDT_MOD)
    ) u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mode_i(q.mode[i]),
      .ccap_i(q.ccap[i]),
      .count_i(q.cnt),
      .tick_i(q.run),
      .watchdog_reset_enable_i(q.watchdog_reset_enable),
      .pin_i(module_pin_i[i]),
      .pin_o(module_pin_o[i]),
      .pin_oe_o(module_pin_oe_o[i]),
      .capture_o(cap_ev[i]),
      .event_o(set_ev[i]),
      .reload_o(reload_ev[i]),
      .wdt_reset_o(wdt_ev[i])
    );
  end

  // address decode of the module banks
  always_comb begin
    mode_hit = ccpa_bank(rif.adr, OFF_MODE0);
    ccap_hit = ccpa_bank(rif.adr, OFF_CCAP0);
    mode_idx = mode_hit[2:0];
    ccap_idx = ccap_hit[2:0];
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rif.rdata = RD_ZERO;
    if (rif.adr == OFF_CTRL) begin
      rif.rdata[NUM_MOD-1:0] = q.flag;
      rif.rdata[CTRL_RUN_BIT] = q.run;
    end else if (rif.adr == OFF_CMODE) begin
      rif.rdata[CMODE_WATCHDOG_RESET_ENABLE_BIT] = q.watchdog_reset_enable;
    end else if (rif.adr == OFF_COUNT) begin
      rif.rdata[CNT_W-1:0] = q.cnt;
    end else if (mode_hit[3]) begin
      // reserved bit 7 and above read zero
      rif.rdata[MODE_W-1:0] = q.mode[mode_idx];
    end else if (ccap_hit[3]) begin
      rif.rdata[CNT_W-1:0] = q.ccap[ccap_idx];
    end
  end

  // next state of counter, flags and registers
  always_comb begin
    d = q;

    // free-running shared counter
    if (q.run) begin
      d.cnt = q.cnt + CNT_W'(1);
    end

    // control register: run bit, write one clears a flag
    if (rif.wr && rif.adr == OFF_CTRL && rif.sel[0]) begin
      d.run = rif.wdata[CTRL_RUN_BIT];
      d.flag = q.flag & ~rif.wdata[NUM_MOD-1:0];
    end

    // counter mode register: watchdog enable
    if (rif.wr && rif.adr == OFF_CMODE && rif.sel[0]) begin
      d.watchdog_reset_enable = rif.wdata[CMODE_WATCHDOG_RESET_ENABLE_BIT];
    end

    // software load of the counter, byte lanes
    if (rif.wr && rif.adr == OFF_COUNT) begin
      if (rif.sel[0]) begin
        d.cnt[BYTE_W-1:0] = rif.wdata[BYTE_W-1:0];
      end
      if (rif.sel[1]) begin
        d.cnt[CNT_W-1:BYTE_W] = rif.wdata[CNT_W-1:BYTE_W];
      end
    end

    // mode registers, reserved bits dropped
    if (rif.wr && mode_hit[3] && rif.sel[0]) begin
      d.mode[mode_idx] = rif.wdata[MODE_W-1:0];
    end

    // capture/compare pairs, byte lanes
    if (rif.wr && ccap_hit[3]) begin
      if (rif.sel[0]) begin
        d.ccap[ccap_idx][BYTE_W-1:0] = rif.wdata[BYTE_W-1:0];
      end
      if (rif.sel[1]) begin
        d.ccap[ccap_idx][CNT_W-1:BYTE_W] = rif.wdata[CNT_W-1:BYTE_W];
      end
    end

    // hardware events win over software in the same cycle
    for (int i = 0; i < NUM_MOD; i++) begin
      if (cap_ev[i]) begin
        // whole counter copied, old value simply lost
        d.ccap[i] = q.cnt;
      end
      if (reload_ev[i]) begin
        // duty change takes effect at the period boundary
        d.ccap[i][BYTE_W-1:0] = d.ccap[i][CNT_W-1:BYTE_W];
      end
      if (set_ev[i]) begin
        d.flag[i] = 1'b1; // set beats clear
      end
    end

    // interrupt from flag and per-module enable
    d.irq = 1'b0;
    for (int i = 0; i < NUM_MOD; i++) begin
      if (d.flag[i] && d.mode[i][MB_IRQ]) begin
        d.irq = 1'b1;
      end
    end

    // internal reset pulse, no external pin driven
    d.wdt_rst = |wdt_ev;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.cnt <= CNT_RST;
      q.run <= 1'b0;
      q.watchdog_reset_enable <= 1'b0;
      q.flag <= '0;
      q.mode <= {NUM_MOD{MODE_RST}};
      q.ccap <= {NUM_MOD{CNT_RST}};
      q.irq <= 1'b0;
      q.wdt_rst <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign irq_o = q.irq;
  assign internal_reset_o = q.wdt_rst;
endmodule : ccpa_top

// File: design/ccpa_pkg.sv
// constants, field layouts and helper functions of the counter array
package ccpa_pkg;
  // structure of the array
  localparam int NUM_MOD = 5; // number of capture/compare modules
  localparam int WDT_MOD = 4; // only module able to act as watchdog
  localparam int CNT_W = 16; // shared counter width
  localparam int BYTE_W = 8; // one byte of a 16-bit value
  localparam int MODE_W = 7; // implemented bits of a mode register
  localparam int DATA_W = 32; // wishbone data width
  localparam int ADR_W = 8; // wishbone byte address width
  localparam int SEL_W = 4; // wishbone byte lanes

  // module mode register bit positions
  localparam int MB_IRQ = 0; // module_irq_enable_bit
  localparam int MB_PWM = 1; // pwm_select_bit
  localparam int MB_TOG = 2; // toggle_enable_bit
  localparam int MB_MAT = 3; // match_flag_enable_bit
  localparam int MB_CAPN = 4; // falling_capture_bit
  localparam int MB_CAPP = 5; // rising_capture_bit
  localparam int MB_ECOM = 6; // compare_enable_bit

  // control and counter mode register bits
  localparam int CTRL_RUN_BIT = 6; // counter run enable
  localparam int CMODE_WATCHDOG_RESET_ENABLE_BIT = 6; // watchdog_reset_enable

  // register byte offsets
  localparam logic [ADR_W-1:0] OFF_CTRL = 8'h00; // counter_control_register
  localparam logic [ADR_W-1:0] OFF_CMODE = 8'h04; // counter_mode_register
  localparam logic [ADR_W-1:0] OFF_COUNT = 8'h08; // shared counter pair
  localparam logic [ADR_W-1:0] OFF_MODE0 = 8'h10; // first module_mode_register
  localparam logic [ADR_W-1:0] OFF_CCAP0 = 8'h30; // first capture/compare pair
  localparam logic [ADR_W-1:0] OFF_STEP = 8'h04; // stride between modules

  // reset values and constants
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [MODE_W-1:0] MODE_RST = 7'h00;
  localparam logic [BYTE_W-1:0] LOW_MAX = 8'hFF; // low byte before wrap
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  // decoded operating mode of one module
  typedef enum logic [3:0] {
    CM_IDLE = 4'h1,
    CM_CAPT = 4'h2,
    CM_CMP = 4'h4,
    CM_PWM = 4'h8
  } ccpa_mode_t;

  // mode bits to operating mode
  function automatic ccpa_mode_t ccpa_decode(input logic [MODE_W-1:0] m);
    if (!m[MB_ECOM] && (m[MB_CAPP] || m[MB_CAPN])) begin
      return CM_CAPT;
    end else if (m[MB_ECOM] && m[MB_PWM] && !m[MB_MAT]) begin
      return CM_PWM;
    end else if (m[MB_ECOM] && m[MB_MAT] && !m[MB_PWM]) begin
      return CM_CMP;
    end
    return CM_IDLE;
  endfunction : ccpa_decode

  // hit test of a per-module register bank, returns {hit, index}
  function automatic logic [3:0] ccpa_bank(input logic [ADR_W-1:0] adr,
                                           input logic [ADR_W-1:0] base);
    logic [ADR_W-1:0] rel;
    rel = adr - base;
    if (adr >= base && rel[1:0] == 2'h0 && rel[ADR_W-1:2] < NUM_MOD) begin
      return {1'b1, rel[4:2]};
    end
    return 4'h0;
  endfunction : ccpa_bank
endpackage : ccpa_pkg

// File: design/ccpa_reg_if.sv
// register access path between the wishbone slave and the register file
`timescale 1ns/1ps
interface ccpa_reg_if;
  import ccpa_pkg::*;
  logic wr; // write strobe, one cycle
  logic [ADR_W-1:0] adr; // byte address
  logic [DATA_W-1:0] wdata; // write data
  logic [SEL_W-1:0] sel; // byte lanes
  logic [DATA_W-1:0] rdata; // read data of the addressed register
  modport port (output wr, output adr, output wdata, output sel,
                input rdata);
  modport regs (input wr, input adr, input wdata, input sel,
                output rdata);
endinterface : ccpa_reg_if

// File: design/ccpa_wb_slave.sv
// classic wishbone slave, one wait state, registered read data
`timescale 1ns/1ps
module ccpa_wb_slave
  import ccpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  ccpa_reg_if.port rif
);
  typedef struct packed {
    logic ack; // acknowledge
    logic [DATA_W-1:0] dat; // read data held during ack
  } ccpa_wb_state_t;

  ccpa_wb_state_t q, d;
  logic req; // live request

  // request decode and next state
  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    d = q;
    d.ack = req & ~q.ack;
    // read data caught at the edge that raises ack
    if (req && !q.ack && !wb_we_i) begin
      d.dat = rif.rdata;
    end
    rif.adr = wb_adr_i;
    rif.wdata = wb_dat_i;
    rif.sel = wb_sel_i;
    // write lands on the edge where the master sees ack
    rif.wr = req & wb_we_i & q.ack;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
endmodule : ccpa_wb_slave

// File: design/ccpa_channel.sv
// one capture/compare module: edge detect, match, toggle, pwm, watchdog
`timescale 1ns/1ps
module ccpa_channel
  import ccpa_pkg::*;
#(
  parameter bit IS_WDT = 1'b0 // watchdog capable module
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [MODE_W-1:0] mode_i, // module mode register
  input wire logic [CNT_W-1:0] ccap_i, // capture/compare pair
  input wire logic [CNT_W-1:0] count_i, // shared counter
  input wire logic tick_i, // counter advances this cycle
  input wire logic watchdog_reset_enable_i, // watchdog_reset_enable
  input wire logic pin_i, // module_pin level
  output logic pin_o, // module_pin drive
  output logic pin_oe_o, // module_pin enable
  output logic capture_o, // capture now
  output logic event_o, // set module_event_flag
  output logic reload_o, // pwm reload high into low byte
  output logic wdt_reset_o // watchdog match
);
  typedef struct packed {
    logic prev; // pin level last cycle
    logic out; // output pin level
  } ccpa_ch_state_t;

  ccpa_ch_state_t q, d;
  ccpa_mode_t mode; // decoded mode
  logic rise, fall, match;

  // mode decode, edge detect and compare
  always_comb begin
    mode = ccpa_decode(mode_i);
    d = q;
    d.prev = pin_i;
    rise = pin_i & ~q.prev;
    fall = ~pin_i & q.prev;
    match = tick_i & (ccap_i == count_i);
    capture_o = 1'b0;
    event_o = 1'b0;
    reload_o = 1'b0;
    wdt_reset_o = 1'b0;
    unique case (mode)
      CM_IDLE: begin
        d.out = q.out; // no operation
      end
      CM_CAPT: begin
        // either edge bit enables capture
        capture_o = (mode_i[MB_CAPP] & rise) | (mode_i[MB_CAPN] & fall);
        event_o = capture_o;
      end
      CM_CMP: begin
        event_o = match;
        if (match && mode_i[MB_TOG]) begin
          d.out = ~q.out;
        end
        // watchdog reset only on module 4 with enable
        wdt_reset_o = IS_WDT & watchdog_reset_enable_i & match;
      end
      CM_PWM: begin // pwm bit together with compare enable
        // low below compare low byte, high at or above
        d.out = (count_i[BYTE_W-1:0] >= ccap_i[BYTE_W-1:0]);
        reload_o = tick_i & (count_i[BYTE_W-1:0] == LOW_MAX);
      end
    endcase
    pin_oe_o = (mode == CM_PWM) | ((mode == CM_CMP) & mode_i[MB_TOG]);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_o = q.out;
endmodule : ccpa_channel

// File: verif/ccpa_monitor.sv
// port-level assertion checker for the counter array top
`timescale 1ns/1ps
module ccpa_monitor
  import ccpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_MOD-1:0] module_pin_i,
  input wire logic [NUM_MOD-1:0] module_pin_o,
  input wire logic [NUM_MOD-1:0] module_pin_oe_o,
  input wire logic irq_o,
  input wire logic internal_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request seen by the slave, not yet answered
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // read answered at this edge
  sequence s_rd_ans;
    wb_ack_o && !wb_we_i;
  endsequence
  chk_ack_one_late: assert property (s_taken |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_reset_clears_all: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !irq_o && !internal_reset_o && module_pin_oe_o == '0)
    else $error("outputs not cleared by reset");
  chk_irq_sw_clear: assert property ($fell(irq_o) |->
    (wb_ack_o && wb_we_i) || ($past(wb_ack_o) && $past(wb_we_i)) ||
    $past(rst_i))
    else $error("interrupt dropped without a write");
  chk_unmapped_zero: assert property (s_rd_ans ##0
    (wb_adr_i[1:0] != 2'h0 || wb_adr_i >= 8'h44) |-> wb_dat_o == RD_ZERO)
    else $error("unmapped read not zero");
  chk_mode_rsvd_zero: assert property (s_rd_ans ##0
    (wb_adr_i >= OFF_MODE0 && wb_adr_i < 8'h24) |->
    wb_dat_o[DATA_W-1:MODE_W] == '0)
    else $error("mode register upper bits not zero");
  chk_oe_by_mode: assert property ($changed(module_pin_oe_o) |->
    (wb_ack_o && wb_we_i) || ($past(wb_ack_o) && $past(wb_we_i)) ||
    $past(rst_i))
    else $error("pin enable changed without a mode write");
  chk_wdt_one_pulse: assert property (internal_reset_o |=>
    !internal_reset_o)
    else $error("internal reset longer than one cycle");
endmodule : ccpa_monitor

bind ccpa_top ccpa_monitor ccpa_monitor_i (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .module_pin_i, .module_pin_o, .module_pin_oe_o, .irq_o,
  .internal_reset_o);

// File: verif/ccpa_pin_model.sv
// far-side model: external pin drivers sharing the module pins
`timescale 1ns/1ps
module ccpa_pin_model
  import ccpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic [NUM_MOD-1:0] lvl_i, // level the far side wants
  input wire logic [NUM_MOD-1:0] pin_o_i, // design drive
  input wire logic [NUM_MOD-1:0] pin_oe_i, // design enable
  output logic [NUM_MOD-1:0] pin_lvl_o // wire level back to design
);
  logic [NUM_MOD-1:0] ext_q; // far-side drive, synchronous
  // far side moves just after an edge, as the design expects
  always_ff @(posedge clk_i) begin
    ext_q <= lvl_i;
  end
  // enabled design drive wins, else the far side level
  assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_q);
endmodule : ccpa_pin_model

// File: verif/testbench.sv
// self-checking bench for the counter array top
`timescale 1ns/1ps
module testbench;
  import ccpa_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [SEL_W-1:0] wb_sel_i = '0;
  logic [DATA_W-1:0] wb_dat_i = '0;
  logic [DATA_W-1:0] wb_dat_o;
  logic wb_ack_o, irq_o, internal_reset_o;
  logic [NUM_MOD-1:0] lvl = '0; // far-side pin levels
  logic [NUM_MOD-1:0] module_pin_i, module_pin_o, module_pin_oe_o;
  logic [DATA_W-1:0] exp_q[$]; // expected read data, oldest first
  int num_errors = 0;
  int compares = 0;
  logic [CNT_W-1:0] b1, b2, k; // random counter values
  logic [7:0] duty; // random pwm reload
  logic seen;
  int h0, h1;
  ccpa_top ccpa_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .module_pin_i,
    .module_pin_o, .module_pin_oe_o, .irq_o, .internal_reset_o);
  ccpa_pin_model ccpa_pin_model_i (.clk_i, .lvl_i(lvl),
    .pin_o_i(module_pin_o), .pin_oe_i(module_pin_oe_o),
    .pin_lvl_o(module_pin_i));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // one counted comparison
  task automatic check(input string what, input logic [DATA_W-1:0] e,
                       input logic [DATA_W-1:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check
  // address of module m in a bank
  function automatic logic [ADR_W-1:0] at(input logic [ADR_W-1:0] base,
                                          input int m);
    return base + OFF_STEP * 8'(m);
  endfunction : at
  // classic wishbone cycle, held until ack, then released a cycle
  task automatic wb(input logic we, input logic [ADR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      conclude();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] d);
    wb(1'b1, a, d);
  endtask : wr
  // read noting the expected answer
  task automatic rd(input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, RD_ZERO);
  endtask : rd
  // internal reset seen within 40 cycles or not
  task automatic watch(input logic e);
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk_i);
      seen |= internal_reset_o;
    end
    check("internal reset", 32'(e), 32'(seen));
  endtask : watch
  // takes the oldest note at every read answer
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      check("read data", exp_q.pop_front(), wb_dat_o);
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'h1BDC));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFF_CTRL, RD_ZERO);
    rd(OFF_MODE0, RD_ZERO);
    wr(8'hF0, 32'hFFFF_FFFF);
    rd(8'hF0, RD_ZERO);
    rd(8'h11, RD_ZERO);
    // capture: rising, falling, both, none, counter stopped
    b1 = 16'($urandom);
    b2 = ~b1;
    wr(at(OFF_MODE0, 0), 32'h21);
    wr(at(OFF_MODE0, 1), 32'h11);
    wr(at(OFF_MODE0, 2), 32'h31);
    wr(at(OFF_MODE0, 3), 32'h01);
    wr(OFF_COUNT, 32'(b1));
    lvl <= 5'h0F;
    repeat (4) @(posedge clk_i);
    rd(at(OFF_CCAP0, 1), RD_ZERO);
    rd(at(OFF_CCAP0, 2), 32'(b1));
    wr(OFF_COUNT, 32'(b2));
    lvl <= 5'h00;
    repeat (4) @(posedge clk_i);
    rd(at(OFF_CCAP0, 0), 32'(b1));
    rd(at(OFF_CCAP0, 1), 32'(b2));
    rd(at(OFF_CCAP0, 2), 32'(b2));
    rd(at(OFF_CCAP0, 3), RD_ZERO);
    rd(OFF_CTRL, 32'h07);
    check("irq", 32'h1, 32'(irq_o));
    wr(OFF_CTRL, 32'h07);
    rd(OFF_CTRL, RD_ZERO);
    check("irq", 32'h0, 32'(irq_o));
    // flag without enable gives no interrupt
    wr(at(OFF_MODE0, 0), 32'h20);
    lvl <= 5'h01;
    repeat (4) @(posedge clk_i);
    rd(OFF_CTRL, 32'h01);
    check("irq", 32'h0, 32'(irq_o));
    for (int m = 0; m < 4; m++) begin
      wr(at(OFF_MODE0, m), RD_ZERO);
    end
    wr(OFF_CTRL, 32'h01);
    // timer with and without toggle
    k = 16'($urandom_range(16'hF000, 16'h0100));
    wr(at(OFF_MODE0, 1), 32'h4C);
    wr(at(OFF_MODE0, 2), 32'h48);
    wr(at(OFF_CCAP0, 1), 32'(k));
    wr(at(OFF_CCAP0, 2), 32'(k));
    wr(OFF_COUNT, 32'(k - 16'd20));
    wr(OFF_CTRL, 32'h40);
    seen = 1'b0;
    for (int n = 0; n < 60 && !seen; n++) begin
      @(posedge clk_i);
      seen = module_pin_o[1];
    end
    check("toggle pin", 32'h1, 32'(seen));
    check("toggle oe", 32'h1, 32'(module_pin_oe_o[1]));
    check("no toggle", 32'h0, 32'(module_pin_o[2]));
    wr(OFF_CTRL, RD_ZERO);
    rd(OFF_CTRL, 32'h06);
    check("irq", 32'h0, 32'(irq_o));
    wr(at(OFF_MODE0, 1), RD_ZERO);
    wr(at(OFF_MODE0, 2), RD_ZERO);
    wr(OFF_CTRL, 32'h06);
    // watchdog: needs enable, module four only
    wr(at(OFF_MODE0, 4), 32'h48);
    wr(at(OFF_CCAP0, 4), 32'h1000);
    wr(OFF_COUNT, 32'h0FF0);
    wr(OFF_CTRL, 32'h40);
    watch(1'b0);
    wr(OFF_CTRL, RD_ZERO);
    wr(OFF_CMODE, 32'h40);
    rd(OFF_CMODE, 32'h40);
    wr(at(OFF_MODE0, 3), 32'h48);
    wr(at(OFF_CCAP0, 3), 32'h2000);
    wr(OFF_COUNT, 32'h1FF0);
    wr(OFF_CTRL, 32'h40);
    watch(1'b0);
    wr(OFF_COUNT, 32'h0FF0);
    watch(1'b1);
    wr(OFF_CTRL, RD_ZERO);
    wr(at(OFF_MODE0, 3), RD_ZERO);
    wr(at(OFF_MODE0, 4), RD_ZERO);
    wr(OFF_CTRL, 32'h18);
    // pwm: reload only at wrap, duty from low byte
    duty = 8'($urandom);
    wr(at(OFF_CCAP0, 0), {16'h0, duty, 8'h5A});
    wr(at(OFF_CCAP0, 1), {16'h0, duty, 8'h5A});
    wr(at(OFF_MODE0, 0), 32'h42);
    wr(at(OFF_MODE0, 1), 32'h43);
    wr(at(OFF_MODE0, 2), 32'h02);
    wr(OFF_COUNT, RD_ZERO);
    rd(at(OFF_CCAP0, 0), {16'h0, duty, 8'h5A});
    wr(OFF_CTRL, 32'h40);
    repeat (300) @(posedge clk_i);
    rd(at(OFF_CCAP0, 0), {16'h0, duty, duty});
    h0 = 0;
    h1 = 0;
    repeat (256) begin
      @(posedge clk_i);
      h0 += int'(module_pin_o[0] === 1'b1);
      h1 += int'(module_pin_o[1] === 1'b1);
    end
    check("pwm high", 32'(256 - int'(duty)), 32'(h0));
    check("pwm irq bit", 32'(h0), 32'(h1));
    check("pwm oe", 32'h3, 32'(module_pin_oe_o));
    conclude();
  end
endmodule : testbench
